// ---- core/lobm_pkg.sv ----
// package: register map, field positions, codes and timing for the
// loop output, burst and multidrop controller.
// assumes a 50 MHz aclk and currents coded in microamps.
package lobm_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_POLL   = 8'h04;
  localparam logic [7:0] OFS_CUSTOM = 8'h08;
  localparam logic [7:0] OFS_ALM_LO = 8'h0C;
  localparam logic [7:0] OFS_ALM_HI = 8'h10;
  localparam logic [7:0] OFS_SIM    = 8'h14;
  localparam logic [7:0] OFS_TRIG   = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;

  // control field positions
  localparam int C_REV7  = 0;
  localparam int C_LTEST = 1;
  localparam int C_LSRC  = 2;
  localparam int C_SIM   = 4;
  localparam int C_SSEL  = 5;
  localparam int C_BURST = 7;
  localparam int C_CONT  = 8;
  localparam int C_TRIG  = 11;

  // status field positions
  localparam int S_MDROP = 0;
  localparam int S_CFGE  = 1;
  localparam int S_ADRE  = 2;
  localparam int S_SIMON = 3;
  localparam int S_BUSY  = 4;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [5:0]  POLL_RST   = 6'h00;
  localparam logic [31:0] ALM_LO_RST = 32'h0F3C_0EA6;
  localparam logic [31:0] ALM_HI_RST = 32'h5140_54F6;

  // currents in microamps
  localparam logic [15:0] MA_LOW  = 16'h0FA0;
  localparam logic [15:0] MA_HIGH = 16'h4E20;
  localparam logic [16:0] MA_SEP  = 17'h00064;

  // poll address limit for protocol revision 5
  localparam logic [5:0] ADDR_MAX5 = 6'h0F;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // loop test sources, simulated variables, burst content and triggers
  localparam logic [1:0] LT_LOW    = 2'h0;
  localparam logic [1:0] LT_HIGH   = 2'h1;
  localparam logic [1:0] LT_CUSTOM = 2'h2;
  localparam logic [1:0] LT_ALARM  = 2'h3;
  localparam logic [1:0] SV_PRES   = 2'h0;
  localparam logic [1:0] SV_TEMP   = 2'h1;
  localparam logic [1:0] SV_SCALED = 2'h2;
  localparam logic [2:0] CONT_PVST = 3'h5;
  localparam logic [2:0] CONT_MAX  = 3'h5;
  localparam logic [2:0] TRIG_CONT = 3'h0;
  localparam logic [2:0] TRIG_RISE = 3'h1;
  localparam logic [2:0] TRIG_FALL = 3'h2;
  localparam logic [2:0] TRIG_WIN  = 3'h3;
  localparam logic [2:0] TRIG_CHG  = 3'h4;

  // idle gap after each burst message
  localparam int CLK_PERIOD_NS = 20;
  localparam int GAP_NS        = 20000;
  localparam logic [15:0] GAP_CYC =
    16'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_GAP  = 2'b10
  } tx_state_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } lite_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lite_rsp_t;

  typedef struct packed {
    logic [15:0] loop_ua;
    logic [15:0] pressure;
    logic [15:0] temp;
    logic [15:0] scaled;
    logic        fault;
    logic        alarm_up;
  } meas_t;

  typedef struct packed {
    logic [15:0] pressure;
    logic [15:0] temp;
    logic [15:0] scaled;
  } dyn_t;

  typedef struct packed {
    logic       valid;
    logic       burst;
    logic [2:0] content;
  } tx_t;

endpackage

// ---- core/loop_output_burst_multidrop.sv ----
// loop output override, variable simulation, burst scheduling and
// poll address handling for a two-wire field transmitter.
// assumes measurement inputs and link strobes are synchronous to aclk.
//
// What this block does
// - loop test forces output to 4 mA, 20 mA or custom current
// - loop test can also force the configured alarm current
// - simulation substitutes a fixed value for pressure, temperature or scaled
// - leaving simulation restores the live value with no further command
// - simulation is refused unless revision 7 operation is selected
// - burst messages carry only dynamic data; other access unchanged
// - while bursting, addressed polls still get ordinary replies
// - each burst is followed by an idle gap for master requests
// - burst may cut non-dynamic reply throughput by half at most
// - burst content selectable; status-with-variables can be set only in revision 7, but is kept on leaving it
// - revision 7 triggers: continuous, rising, falling, windowed, change
// - poll address resets to zero; address zero tracks primary variable
// - multidrop when address is 1..15 (rev 5) or 1..63 (rev 7)
// - multidrop parks the analog output at 4 mA outside loop test
// - multidrop drops the switch-selected alarm current
// - answer only requests carrying our own poll address
// - multidrop saturation and alarm leave the analog output alone
// - alarm and saturation must be 0.1 mA apart, else refused
`timescale 1ns/10ps
module loop_output_burst_multidrop
  import lobm_pkg::*;
(
  // clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // register bus
  input  wire lite_req_t axi_req,
  output      lite_rsp_t axi_rsp,
  // live measurement
  input  wire meas_t     meas,
  // link requests
  input  wire logic      rx_valid,
  input  wire logic [5:0] rx_addr,
  input  wire logic      tx_ready,
  // link and loop outputs
  output      tx_t       tx,
  output      logic [15:0] loop_ua,
  output      dyn_t      dyn,
  output      logic      multidrop
);

  typedef struct packed {
    lite_rsp_t   rsp;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [31:0] ctrl;
    logic [5:0]  poll;
    logic [15:0] custom;
    logic [31:0] alm_lo;
    logic [31:0] alm_hi;
    logic [15:0] sim_val;
    logic [15:0] trig;
    logic        cfg_err;
    logic        addr_err;
    logic [15:0] loop_ua;
    logic        multidrop;
    dyn_t        dyn;
    tx_state_t   st;
    tx_t         tx;
    logic [15:0] gap;
    logic        rx_pend;
    logic        last_burst;
    logic [15:0] last_primary;
  } st_t;

  st_t q;
  st_t n;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic        rev7;
  logic        sim_on;
  logic [1:0]  lsrc;
  logic [2:0]  trig_sel;
  logic [15:0] primary_variable;
  logic [15:0] diff;
  logic [15:0] alarm_ua;
  logic        trig_hit;
  logic        burst_due;

  assign rev7     = q.ctrl[C_REV7];
  assign sim_on   = q.ctrl[C_SIM] && rev7;
  assign lsrc     = q.ctrl[C_LSRC +: 2];
  assign trig_sel = q.ctrl[C_TRIG +: 3];
  assign primary_variable = q.dyn.pressure;
  assign diff     = (primary_variable > q.last_primary) ?
                    primary_variable - q.last_primary :
                    q.last_primary - primary_variable;
  // the switch picks which alarm is driven outside multidrop
  assign alarm_ua = meas.alarm_up ? q.alm_hi[15:0] : q.alm_lo[15:0];

  // revision 5 bursts only ever run continuously
  always_comb begin
    trig_hit = 1'b1;
    if (rev7) begin
      case (trig_sel)
        TRIG_CONT: trig_hit = 1'b1;
        TRIG_RISE: trig_hit = primary_variable > q.trig;
        TRIG_FALL: trig_hit = primary_variable < q.trig;
        TRIG_WIN:  trig_hit = diff > q.trig;
        TRIG_CHG:  trig_hit = primary_variable != q.last_primary;
        default:   trig_hit = 1'b1;
      endcase
    end
  end
  assign burst_due = q.ctrl[C_BURST] && trig_hit;

  always_comb begin
    logic [31:0] v;
    n = q;
    v = merge(q.ctrl, q.wdata, q.wstrb);
    // write channel: address and data are taken in either order
    if (axi_req.awvalid && q.rsp.awready) begin
      n.waddr = axi_req.awaddr;
      n.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && q.rsp.wready) begin
      n.wdata = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
      n.rsp.wready = 1'b0;
    end
    if (!q.rsp.awready && !q.rsp.wready && !q.rsp.bvalid) begin
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp  = RESP_OK;
      case (q.waddr)
        OFS_CTRL: begin
          // leaving revision 7 with a high address would strand it
          if (!v[C_REV7] && q.poll > ADDR_MAX5) begin
            v[C_REV7] = 1'b1;
            n.addr_err = 1'b1;
          end
          if (!v[C_REV7]) begin
            v[C_SIM] = 1'b0;
          end
          if ((!v[C_REV7] && v[C_CONT +: 3] == CONT_PVST) ||
              v[C_CONT +: 3] > CONT_MAX) begin
            v[C_CONT +: 3] = q.ctrl[C_CONT +: 3];
          end
          n.ctrl = v;
        end
        OFS_POLL: begin
          v = merge({26'h0, q.poll}, q.wdata, q.wstrb);
          if (v[31:6] != 26'h0 || (!rev7 && v[5:0] > ADDR_MAX5)) begin
            n.addr_err = 1'b1;
          end else begin
            n.poll = v[5:0];
          end
        end
        OFS_CUSTOM: n.custom = 16'(merge({16'h0, q.custom}, q.wdata,
                                         q.wstrb));
        OFS_ALM_LO: begin
          v = merge(q.alm_lo, q.wdata, q.wstrb);
          if ({1'b0, v[15:0]} + MA_SEP > {1'b0, v[31:16]}) begin
            n.cfg_err = 1'b1;
          end else begin
            n.alm_lo = v;
          end
        end
        OFS_ALM_HI: begin
          v = merge(q.alm_hi, q.wdata, q.wstrb);
          if ({1'b0, v[31:16]} + MA_SEP > {1'b0, v[15:0]}) begin
            n.cfg_err = 1'b1;
          end else begin
            n.alm_hi = v;
          end
        end
        OFS_SIM:  n.sim_val = 16'(merge({16'h0, q.sim_val}, q.wdata,
                                        q.wstrb));
        OFS_TRIG: n.trig = 16'(merge({16'h0, q.trig}, q.wdata, q.wstrb));
        OFS_STAT: begin
          if (q.wstrb[0] && q.wdata[S_CFGE]) begin
            n.cfg_err = 1'b0;
          end
          if (q.wstrb[0] && q.wdata[S_ADRE]) begin
            n.addr_err = 1'b0;
          end
        end
        default: n.rsp.bresp = RESP_ERR;
      endcase
    end
    if (q.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid  = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready  = 1'b1;
    end
    // read channel
    if (axi_req.arvalid && q.rsp.arready) begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid  = 1'b1;
      n.rsp.rresp   = RESP_OK;
      case (axi_req.araddr)
        OFS_CTRL:   n.rsp.rdata = q.ctrl;
        OFS_POLL:   n.rsp.rdata = {26'h0, q.poll};
        OFS_CUSTOM: n.rsp.rdata = {16'h0, q.custom};
        OFS_ALM_LO: n.rsp.rdata = q.alm_lo;
        OFS_ALM_HI: n.rsp.rdata = q.alm_hi;
        OFS_SIM:    n.rsp.rdata = {16'h0, q.sim_val};
        OFS_TRIG:   n.rsp.rdata = {16'h0, q.trig};
        OFS_STAT:   n.rsp.rdata = {27'h0, q.st != TX_IDLE, sim_on,
                                   q.addr_err, q.cfg_err, q.multidrop};
        default: begin
          n.rsp.rdata = 32'h0000_0000;
          n.rsp.rresp = RESP_ERR;
        end
      endcase
    end
    if (q.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid  = 1'b0;
      n.rsp.arready = 1'b1;
    end

    // address zero is point-to-point; any other legal address multidrops
    n.multidrop = q.poll != POLL_RST;
    // test override first; it ends the cycle its bit drops
    if (q.ctrl[C_LTEST]) begin
      case (lsrc)
        LT_LOW:    n.loop_ua = MA_LOW;
        LT_HIGH:   n.loop_ua = MA_HIGH;
        LT_CUSTOM: n.loop_ua = q.custom;
        LT_ALARM:  n.loop_ua = alarm_ua;
        default:   n.loop_ua = MA_LOW;
      endcase
    end else if (q.multidrop) begin
      n.loop_ua = MA_LOW;
    end else if (meas.fault) begin
      n.loop_ua = alarm_ua;
    end else if (meas.loop_ua < q.alm_lo[31:16]) begin
      n.loop_ua = q.alm_lo[31:16];
    end else if (meas.loop_ua > q.alm_hi[31:16]) begin
      n.loop_ua = q.alm_hi[31:16];
    end else begin
      n.loop_ua = meas.loop_ua;
    end

    // substitution stops the cycle simulation is switched off
    n.dyn.pressure = (sim_on && q.ctrl[C_SSEL +: 2] == SV_PRES) ?
                     q.sim_val : meas.pressure;
    n.dyn.temp     = (sim_on && q.ctrl[C_SSEL +: 2] == SV_TEMP) ?
                     q.sim_val : meas.temp;
    n.dyn.scaled   = (sim_on && q.ctrl[C_SSEL +: 2] == SV_SCALED) ?
                     q.sim_val : meas.scaled;

    // link scheduler: replies and bursts alternate when both wait
    case (q.st)
      TX_IDLE: begin
        if (q.rx_pend && (!burst_due || q.last_burst)) begin
          n.tx.valid   = 1'b1;
          n.tx.burst   = 1'b0;
          n.rx_pend    = 1'b0;
          n.last_burst = 1'b0;
          n.st         = TX_SEND;
        end else if (burst_due) begin
          n.tx.valid   = 1'b1;
          n.tx.burst   = 1'b1;
          n.tx.content = q.ctrl[C_CONT +: 3];
          n.last_primary = primary_variable;
          n.last_burst = 1'b1;
          n.st         = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_ready) begin
          n.tx.valid = 1'b0;
          n.gap      = GAP_CYC - 16'h0001;
          n.st       = q.tx.burst ? TX_GAP : TX_IDLE;
        end
      end
      TX_GAP: begin
        if (q.gap == 16'h0000) begin
          n.st = TX_IDLE;
        end else begin
          n.gap = q.gap - 16'h0001;
        end
      end
      default: n.st = TX_IDLE;
    endcase
    // a request landing as the previous one is taken is kept
    if (rx_valid && rx_addr == q.poll) begin
      n.rx_pend = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q             <= '0;
      q.rsp.awready <= 1'b1;
      q.rsp.wready  <= 1'b1;
      q.rsp.arready <= 1'b1;
      q.ctrl        <= CTRL_RST;
      q.poll        <= POLL_RST;
      q.alm_lo      <= ALM_LO_RST;
      q.alm_hi      <= ALM_HI_RST;
      q.loop_ua     <= MA_LOW;
      q.st          <= TX_IDLE;
    end else begin
      q <= n;
    end
  end

  // readies stand high from reset so the first request is taken at once
  assign axi_rsp   = q.rsp;
  assign tx        = q.tx;
  assign loop_ua   = q.loop_ua;
  assign dyn       = q.dyn;
  assign multidrop = q.multidrop;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_LOOP_FORCE: assert property (
    q.ctrl[C_LTEST] && lsrc == LT_HIGH |=> q.loop_ua == MA_HIGH)
    else $error("loop test high level not driven");
  AST_LOOP_ALARM: assert property (
    q.ctrl[C_LTEST] && lsrc == LT_ALARM && meas.alarm_up
    |=> q.loop_ua == $past(q.alm_hi[15:0]))
    else $error("loop test alarm level not driven");
  AST_SIM_SUB: assert property (
    sim_on && q.ctrl[C_SSEL +: 2] == SV_TEMP
    |=> q.dyn.temp == $past(q.sim_val))
    else $error("simulated value not substituted");
  AST_SIM_END: assert property (
    !sim_on |=> q.dyn.pressure == $past(meas.pressure))
    else $error("live value not restored");
  AST_SIM_REV: assert property (
    !rev7 |-> !q.ctrl[C_SIM])
    else $error("simulation enabled outside revision 7");
  AST_POLL_RANGE: assert property (
    !rev7 |-> q.poll <= ADDR_MAX5)
    else $error("poll address beyond revision 5 range");
  AST_MDROP_PARK: assert property (
    q.multidrop && !q.ctrl[C_LTEST] |=> q.loop_ua == MA_LOW)
    else $error("multidrop output not parked");
  AST_GAP_IDLE: assert property (
    q.tx.valid && q.tx.burst && tx_ready |=> !q.tx.valid [*8])
    else $error("burst gap too short");
  AST_OWN_ADDR: assert property (
    $rose(q.rx_pend) |-> $past(rx_addr) == $past(q.poll))
    else $error("foreign address accepted");
  AST_ALTERNATE: assert property (
    q.st == TX_IDLE && q.rx_pend && q.last_burst
    |=> q.tx.valid && !q.tx.burst)
    else $error("reply starved by burst");
  AST_SEPARATION: assert property (
    {1'b0, q.alm_lo[15:0]} + MA_SEP <= {1'b0, q.alm_lo[31:16]})
    else $error("low alarm too close to saturation");

endmodule

// ---- testbench/hart_master_model.sv ----
// link master model: sends polls and accepts the device's messages.
// assumes tx is synchronous to aclk; slow mode stalls each acceptance.
`timescale 1ns/10ps
module hart_master_model
  import lobm_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench control
  input  wire logic       poll_go,
  input  wire logic [5:0] poll_addr,
  input  wire logic       slow,
  // link
  input  wire tx_t        tx,
  output      logic       rx_valid,
  output      logic [5:0] rx_addr,
  output      logic       tx_ready
);
  int wait_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid <= 1'b0;
      rx_addr  <= 6'h00;
      tx_ready <= 1'b0;
      wait_q   <= 0;
    end else begin
      // polls leave at once so they start inside the idle gap
      rx_valid <= poll_go;
      // idle address toggles so a stale value never passes for a poll
      rx_addr  <= poll_go ? poll_addr : ~rx_addr;
      if (tx.valid && tx_ready) begin
        tx_ready <= 1'b0;
        wait_q   <= slow ? 3 : 0;
      end else if (tx.valid && wait_q == 0) begin
        tx_ready <= 1'b1;
      end else if (wait_q > 0) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule

// ---- testbench/test_loop_output_burst_multidrop.sv ----
// bench for the loop output, burst and multidrop controller.
// assumes the link master model on the far side and a lite master here.
`timescale 1ns/10ps
module test_loop_output_burst_multidrop
  import lobm_pkg::*;
;
  logic        aclk, aresetn, poll_go, slow, hit;
  logic [5:0]  poll_addr, rx_addr;
  logic        rx_valid, tx_ready, multidrop;
  lite_req_t   req;
  lite_rsp_t   rsp;
  meas_t       meas;
  tx_t         tx;
  dyn_t        dyn;
  logic [15:0] loop_ua, cust, v;
  logic [31:0] rd;
  logic [1:0]  rr;
  int          fails = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          seed = 32'h7d3d;
  int          k;

  loop_output_burst_multidrop dut_u (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .meas(meas), .rx_valid(rx_valid), .rx_addr(rx_addr),
    .tx_ready(tx_ready), .tx(tx), .loop_ua(loop_ua), .dyn(dyn),
    .multidrop(multidrop));

  hart_master_model master_u (
    .aclk(aclk), .aresetn(aresetn), .poll_go(poll_go),
    .poll_addr(poll_addr), .slow(slow), .tx(tx), .rx_valid(rx_valid),
    .rx_addr(rx_addr), .tx_ready(tx_ready));

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang in any handshake ends here
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  function automatic logic [31:0] ctl(input logic r7, lt,
      input logic [1:0] src, input logic sm, input logic [1:0] ss,
      input logic bu, input logic [2:0] co);
    ctl = {18'h0, TRIG_CONT, co, bu, ss, sm, src, lt, r7};
  endfunction

  function automatic logic [15:0] lt_exp(input logic [1:0] s,
      input logic up);
    case (s)
      LT_LOW:    lt_exp = MA_LOW;
      LT_HIGH:   lt_exp = MA_HIGH;
      LT_CUSTOM: lt_exp = cust;
      default:   lt_exp = up ? ALM_HI_RST[15:0] : ALM_LO_RST[15:0];
    endcase
  endfunction

  function automatic logic [15:0] pick(input int n);
    case (n)
      0:       pick = loop_ua;
      1:       pick = dyn.pressure;
      2:       pick = dyn.temp;
      3:       pick = dyn.scaled;
      4:       pick = {15'h0, multidrop};
      5:       pick = meas.pressure;
      6:       pick = meas.temp;
      default: pick = meas.scaled;
    endcase
  endfunction

  // levels settle within a few cycles; the wait is bounded
  task automatic see(input int n, input logic [15:0] e, input string nm);
    int t;
    t = 0;
    @(negedge aclk);
    while (t < 8 && pick(n) !== e) begin
      @(negedge aclk);
      t++;
    end
    chk(nm, pick(n), e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int t;
    b = 1'b0;
    t = 0;
    @(posedge aclk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    while (!b && t < 100) begin
      @(negedge aclk);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      rr = rsp.bresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      t++;
    end
    req.bready <= 1'b0;
    chk("bvalid", b, 1'b1);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic ar, r;
    int t;
    r = 1'b0;
    t = 0;
    @(posedge aclk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    while (!r && t < 100) begin
      @(negedge aclk);
      ar = req.arvalid & rsp.arready;
      r = rsp.rvalid;
      rd = rsp.rdata;
      rr = rsp.rresp;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'b0;
      t++;
    end
    req.rready <= 1'b0;
    chk("rvalid", r, 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input string nm);
    rd_reg(a);
    chk(nm, rd, e);
  endtask

  task automatic new_meas(input logic up);
    @(posedge aclk);
    meas.loop_ua  <= 16'(MA_LOW + $unsigned($random(seed)) % 16001);
    meas.pressure <= 16'($random(seed));
    meas.temp     <= 16'($random(seed));
    meas.scaled   <= 16'($random(seed));
    meas.fault    <= up;
    meas.alarm_up <= up;
    cust = 16'(MA_LOW + $unsigned($random(seed)) % 16001);
    @(negedge aclk);
  endtask

  task automatic poll(input logic [5:0] a);
    @(posedge aclk);
    poll_go   <= 1'b1;
    poll_addr <= a;
    @(posedge aclk);
    poll_go   <= 1'b0;
  endtask

  task automatic wait_tx(input logic b, input logic [2:0] c, input int lim);
    int t;
    hit = 1'b0;
    for (t = 0; t < lim && !hit; t++) begin
      @(negedge aclk);
      hit = tx.valid && tx.burst === b && (!b || tx.content === c);
    end
  endtask

  // counts low cycles between an accepted burst and the next offer
  task automatic gap;
    int t, lo;
    t = 0;
    lo = 0;
    while (tx.valid && t < 100) begin
      @(negedge aclk);
      t++;
    end
    while (!tx.valid && lo < 1100) begin
      @(negedge aclk);
      lo++;
    end
    chk("gap", lo >= GAP_CYC, 1'b1);
  endtask

  initial begin
    aresetn = 1'b0;
    req = '0;
    meas = '0;
    poll_go = 1'b0;
    poll_addr = 6'h00;
    slow = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    new_meas(1'b0);
    see(4, 16'h0, "multidrop");
    rd_chk(OFS_POLL, 32'h0, "poll_rst");
    rd_chk(OFS_ALM_HI, ALM_HI_RST, "alm_hi");
    see(0, meas.loop_ua, "track");
    rd_reg(8'h40);
    chk("rresp", {30'h0, rr}, {30'h0, RESP_ERR});
    wr(8'h44, 32'h1);
    chk("bresp", {30'h0, rr}, {30'h0, RESP_ERR});
    for (k = 0; k < 8; k++) begin
      new_meas(k[2]);
      wr(OFS_CUSTOM, {16'h0, cust});
      wr(OFS_CTRL, ctl(1'b0, 1'b1, k[1:0], 1'b0, 2'h0, 1'b0, 3'h0));
      see(0, lt_exp(k[1:0], k[2]), "loop_test");
    end
    new_meas(1'b0);
    wr(OFS_CTRL, 32'h0);
    see(0, meas.loop_ua, "loop_end");
    v = 16'($random(seed));
    wr(OFS_SIM, {16'h0, v});
    wr(OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 1'b1, 2'h0, 1'b0, 3'h0));
    see(1, meas.pressure, "sim_rev5");
    for (k = 0; k < 3; k++) begin
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 1'b1, k[1:0], 1'b0, 3'h0));
      see(k + 1, v, "sim_on");
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 1'b0, k[1:0], 1'b0, 3'h0));
      see(k + 1, pick(k + 5), "sim_off");
    end
    // separation below the minimum, then exactly the minimum
    wr(OFS_ALM_LO, 32'h0F3C_0F0A);
    rd_chk(OFS_ALM_LO, ALM_LO_RST, "alm_refused");
    rd_reg(OFS_STAT);
    chk("cfg_err", rd[S_CFGE], 1'b1);
    wr(OFS_ALM_LO, 32'h0F3C_0ED8);
    rd_chk(OFS_ALM_LO, 32'h0F3C_0ED8, "alm_ok");
    wr(OFS_CTRL, 32'h0);
    poll(6'h00);
    wait_tx(1'b0, 3'h0, 3000);
    chk("reply", hit, 1'b1);
    poll(6'h05);
    wait_tx(1'b0, 3'h0, 100);
    chk("foreign", hit, 1'b0);
    wr(OFS_POLL, 32'h10);
    rd_chk(OFS_POLL, 32'h0, "poll_refused");
    wr(OFS_POLL, {26'h0, ADDR_MAX5});
    see(4, 16'h1, "multidrop");
    new_meas(1'b1);
    see(0, MA_LOW, "park");
    wr(OFS_CTRL, ctl(1'b0, 1'b1, LT_HIGH, 1'b0, 2'h0, 1'b0, 3'h0));
    see(0, MA_HIGH, "md_test");
    wr(OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b0, 3'h0));
    see(0, MA_LOW, "md_end");
    wr(OFS_POLL, 32'h3F);
    rd_chk(OFS_POLL, 32'h3F, "poll63");
    poll(6'h3F);
    wait_tx(1'b0, 3'h0, 3000);
    chk("md_reply", hit, 1'b1);
    poll(6'h00);
    wait_tx(1'b0, 3'h0, 100);
    chk("md_foreign", hit, 1'b0);
    wr(OFS_POLL, 32'h0);
    new_meas(1'b0);
    see(4, 16'h0, "p2p");
    for (k = 0; k <= CONT_MAX; k++) begin
      slow <= k[0];
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1, k[2:0]));
      wait_tx(1'b1, k[2:0], 3000);
      chk("burst", hit, 1'b1);
      gap();
    end
    // poll while bursting; the reply must still come
    wait_tx(1'b1, CONT_PVST, 3000);
    while (tx.valid) @(negedge aclk);
    poll(6'h00);
    wait_tx(1'b0, 3'h0, 3000);
    chk("burst_reply", hit, 1'b1);
    // rising above full scale never fires; falling below it does
    wr(OFS_CTRL, 32'h1);
    wr(OFS_TRIG, 32'hFFFF);
    while (tx.valid) @(negedge aclk);
    wr(OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1, 3'h0) |
       (32'(TRIG_RISE) << C_TRIG));
    wait_tx(1'b1, 3'h0, 1200);
    chk("trig_rise", hit, 1'b0);
    wr(OFS_CTRL, ctl(1'b1, 1'b0, 2'h0, 1'b0, 2'h0, 1'b1, 3'h0) |
       (32'(TRIG_FALL) << C_TRIG));
    wait_tx(1'b1, 3'h0, 1200);
    chk("trig_fall", hit, meas.pressure != 16'hFFFF);
    complete_run();
  end
endmodule
